// *** hdl/encoder_scaling_pkg.sv ***
// package: object indices, field positions, reset values and abort codes
package encoder_scaling_pkg;
  // object indices
  localparam logic [15:0] IDX_OPERATING_OPTIONS = 16'h2100;
  localparam logic [15:0] IDX_STEPS_PER_TURN = 16'h2101;
  localparam logic [15:0] IDX_TOTAL_MEASURING_UNITS = 16'h2102;
  localparam logic [15:0] IDX_PRESET_POSITION = 16'h2103;
  localparam logic [15:0] IDX_LOWER_LIMIT_VALUE = 16'h2104;
  localparam logic [15:0] IDX_UPPER_LIMIT_VALUE = 16'h2105;
  localparam logic [15:0] IDX_USER_STORE = 16'h2160;
  // user store layout
  localparam logic [7:0] SUB_USER_STORE_COUNT = 8'h00;
  localparam int USER_STORE_WORDS = 4;
  localparam logic [7:0] USER_STORE_COUNT_VALUE = 8'h04;
  // operating option bit positions
  localparam int OPT_COUNTERCLOCKWISE_RISING = 0;
  localparam int OPT_LOWER_CHECK_EN = 1;
  localparam int OPT_UPPER_CHECK_EN = 2;
  localparam int OPT_WIDTH = 8;
  // process word layout
  localparam int PW_LOWER_FLAG = 30;
  localparam int PW_UPPER_FLAG = 31;
  localparam int PW_VALUE_BITS = 30;
  // reset values
  localparam logic [7:0] OPERATING_OPTIONS_RESET = 8'h00;
  localparam logic [31:0] PRESET_POSITION_RESET = 32'h0000_0000;
  localparam logic [31:0] LOWER_LIMIT_RESET = 32'h0000_0000;
  localparam logic [31:0] UPPER_LIMIT_RESET = 32'h0000_0000;
  localparam logic [31:0] USER_STORE_RESET = 32'h0000_0000;
  // abort codes
  localparam logic [31:0] ABORT_VALUE_RANGE = 32'h0609_0030;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
  localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h0609_0011;
  localparam logic [31:0] ABORT_NONE = 32'h0000_0000;
endpackage

// *** hdl/encoder_position_scaling_limits.sv ***
// position scaling, preset, limit flags and user storage of the encoder
`timescale 1ns/1ps
`default_nettype none
module encoder_position_scaling_limits
  import encoder_scaling_pkg::*;
#(
  parameter int ANGLE_BITS = 12,
  parameter int TURN_BITS = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ANGLE_BITS-1:0] sensor_angle,
  input wire logic [TURN_BITS-1:0] sensor_turns,
  input wire logic msg_strobe,
  input wire logic par_req,
  input wire logic par_write,
  input wire logic [15:0] par_index,
  input wire logic [7:0] par_subindex,
  input wire logic [31:0] par_wdata,
  output logic par_ack,
  output logic par_abort,
  output logic [31:0] par_abort_code,
  output logic [31:0] par_rdata,
  output logic [31:0] process_word,
  output logic process_valid
);
  // physical resolution and the largest sensor codes
  localparam logic [31:0] PHYS_STEPS = 32'(64'd1 << ANGLE_BITS);
  localparam logic [31:0] PHYS_TOTAL = 32'(64'd1 << (ANGLE_BITS + TURN_BITS));
  localparam logic [ANGLE_BITS-1:0] ANGLE_MAX = '1;
  localparam logic [TURN_BITS-1:0] TURN_MAX = '1;

  // configuration state and position datapath
  logic [OPT_WIDTH-1:0] options_reg;
  logic [31:0] steps_reg;
  logic [31:0] total_reg;
  logic [31:0] preset_reg;
  logic [31:0] lower_reg;
  logic [31:0] upper_reg;
  logic [31:0] offset_reg;
  logic [31:0] offset_next;
  logic [31:0] store_reg [USER_STORE_WORDS];
  logic [ANGLE_BITS-1:0] angle_dir;
  logic [TURN_BITS-1:0] turns_dir;
  logic [63:0] angle_scaled;
  logic [63:0] raw_scaled;
  logic [31:0] pos_mod;
  logic [32:0] pos_sum;
  logic [31:0] value_now;
  logic lower_hit;
  logic upper_hit;
  logic wr_ok;
  logic [31:0] abort_next;
  logic [31:0] rdata_next;
  logic [31:0] single_rdata;
  logic single_hit;
  logic range_bad;
  logic [1:0] store_sel;
  logic [31:0] store_rdata;
  logic [31:0] word_next;

  // direction by complementing the physical code
  always_comb begin
    angle_dir = options_reg[OPT_COUNTERCLOCKWISE_RISING] ? ANGLE_MAX - sensor_angle
                                                         : sensor_angle;
    turns_dir = options_reg[OPT_COUNTERCLOCKWISE_RISING] ? TURN_MAX - sensor_turns
                                                         : sensor_turns;
  end

  // scale turns and angle to programmed counts, wrap over total range
  always_comb begin
    angle_scaled = (64'(angle_dir) * 64'(steps_reg)) >> ANGLE_BITS;
    raw_scaled = 64'(turns_dir) * 64'(steps_reg) + angle_scaled;
    if (total_reg == 32'h0000_0000) begin
      pos_mod = 32'h0000_0000;
    end else begin
      pos_mod = 32'(raw_scaled % 64'(total_reg));
    end
    pos_sum = 33'(pos_mod) + 33'(offset_reg);
    if (total_reg == 32'h0000_0000) begin
      value_now = 32'h0000_0000;
    end else begin
      value_now = 32'(pos_sum % 33'(total_reg));
    end
  end

  // limit comparisons gated by their enables
  always_comb begin
    lower_hit = options_reg[OPT_LOWER_CHECK_EN] && (value_now <= lower_reg);
    upper_hit = options_reg[OPT_UPPER_CHECK_EN] && (value_now >= upper_reg);
  end

  // offset that maps the present position onto the preset
  always_comb begin
    if (total_reg == 32'h0000_0000) begin
      offset_next = 32'h0000_0000;
    end else begin
      offset_next = 32'((33'(par_wdata) + 33'(total_reg) - 33'(pos_mod))
                        % 33'(total_reg));
    end
  end

  // present contents of the single-entry objects
  always_comb begin
    case (par_index)
      IDX_OPERATING_OPTIONS: single_rdata = 32'(options_reg);
      IDX_STEPS_PER_TURN: single_rdata = steps_reg;
      IDX_TOTAL_MEASURING_UNITS: single_rdata = total_reg;
      IDX_PRESET_POSITION: single_rdata = preset_reg;
      IDX_LOWER_LIMIT_VALUE: single_rdata = lower_reg;
      IDX_UPPER_LIMIT_VALUE: single_rdata = upper_reg;
      default: single_rdata = 32'h0000_0000;
    endcase
  end

  // whether the access names one of the single-entry objects
  always_comb begin
    case (par_index)
      IDX_OPERATING_OPTIONS, IDX_STEPS_PER_TURN, IDX_TOTAL_MEASURING_UNITS,
      IDX_PRESET_POSITION, IDX_LOWER_LIMIT_VALUE, IDX_UPPER_LIMIT_VALUE: begin
        single_hit = 1'b1;
      end
      default: begin
        single_hit = 1'b0;
      end
    endcase
  end

  // value range of write data; zero steps or total would stall the scaling
  always_comb begin
    case (par_index)
      IDX_OPERATING_OPTIONS: begin
        range_bad = (par_wdata > 32'(8'hff));
      end
      IDX_STEPS_PER_TURN: begin
        range_bad = (par_wdata > PHYS_STEPS) || (par_wdata == 32'h0000_0000);
      end
      IDX_TOTAL_MEASURING_UNITS: begin
        range_bad = (par_wdata > PHYS_TOTAL) || (par_wdata == 32'h0000_0000);
      end
      IDX_PRESET_POSITION, IDX_LOWER_LIMIT_VALUE, IDX_UPPER_LIMIT_VALUE: begin
        range_bad = (par_wdata > total_reg);
      end
      default: begin
        range_bad = 1'b0;
      end
    endcase
  end

  // user word picked by subindex 1 to 4
  always_comb begin
    store_sel = 2'(par_subindex - 8'h01);
    store_rdata = store_reg[store_sel];
  end

  // decode a parameter access: abort code and read data
  always_comb begin
    abort_next = ABORT_NONE;
    rdata_next = 32'h0000_0000;
    if (single_hit) begin
      if (par_subindex != 8'h00) begin
        abort_next = ABORT_NO_SUBINDEX;
      end else if (par_write && range_bad) begin
        abort_next = ABORT_VALUE_RANGE;
      end else if (!par_write) begin
        rdata_next = single_rdata;
      end
    end else if (par_index == IDX_USER_STORE) begin
      if (par_subindex == SUB_USER_STORE_COUNT) begin
        if (par_write) begin
          abort_next = ABORT_READ_ONLY;
        end else begin
          rdata_next = 32'(USER_STORE_COUNT_VALUE);
        end
      end else if (par_subindex > 8'(USER_STORE_WORDS)) begin
        abort_next = ABORT_NO_SUBINDEX;
      end else if (!par_write) begin
        rdata_next = store_rdata;
      end
    end else begin
      abort_next = ABORT_NO_OBJECT;
    end
  end

  assign wr_ok = par_req && par_write && (abort_next == ABORT_NONE);

  // configuration objects of the scaling
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      options_reg <= OPERATING_OPTIONS_RESET;
      steps_reg <= PHYS_STEPS;
      total_reg <= PHYS_TOTAL;
    end else if (wr_ok && par_subindex == 8'h00) begin
      case (par_index)
        IDX_OPERATING_OPTIONS: options_reg <= par_wdata[OPT_WIDTH-1:0];
        IDX_STEPS_PER_TURN: steps_reg <= par_wdata;
        IDX_TOTAL_MEASURING_UNITS: total_reg <= par_wdata;
        default: ;
      endcase
    end
  end

  // preset and limit objects
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      preset_reg <= PRESET_POSITION_RESET;
      lower_reg <= LOWER_LIMIT_RESET;
      upper_reg <= UPPER_LIMIT_RESET;
    end else if (wr_ok && par_subindex == 8'h00) begin
      case (par_index)
        IDX_PRESET_POSITION: preset_reg <= par_wdata;
        IDX_LOWER_LIMIT_VALUE: lower_reg <= par_wdata;
        IDX_UPPER_LIMIT_VALUE: upper_reg <= par_wdata;
        default: ;
      endcase
    end
  end

  // offset taken on a preset write; later steps, total or direction changes
  // leave it as it is, so the preset must be written again after them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      offset_reg <= 32'h0000_0000;
    end else if (wr_ok && par_index == IDX_PRESET_POSITION && par_subindex == 8'h00) begin
      offset_reg <= offset_next;
    end
  end

  // user storage words
  genvar gi;
  generate
    for (gi = 0; gi < USER_STORE_WORDS; gi++) begin : g_store
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          store_reg[gi] <= USER_STORE_RESET;
        end else if (wr_ok && par_index == IDX_USER_STORE
                     && par_subindex == 8'(gi + 1)) begin
          store_reg[gi] <= par_wdata;
        end
      end
    end
  endgenerate

  // answer pulse, one cycle after the request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      par_ack <= 1'b0;
    end else begin
      par_ack <= par_req;
    end
  end

  // answer contents, held until the next request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      par_abort <= 1'b0;
      par_abort_code <= ABORT_NONE;
      par_rdata <= 32'h0000_0000;
    end else if (par_req) begin
      par_abort <= (abort_next != ABORT_NONE);
      par_abort_code <= abort_next;
      par_rdata <= (abort_next == ABORT_NONE) ? rdata_next : 32'h0000_0000;
    end
  end

  // process word from the value and flags of this cycle
  always_comb begin
    word_next = 32'h0000_0000;
    word_next[PW_VALUE_BITS-1:0] = value_now[PW_VALUE_BITS-1:0];
    word_next[PW_LOWER_FLAG] = lower_hit;
    word_next[PW_UPPER_FLAG] = upper_hit;
  end

  // message pulse, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      process_valid <= 1'b0;
    end else begin
      process_valid <= msg_strobe;
    end
  end

  // process word captured for each outgoing message, held until the next
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      process_word <= 32'h0000_0000;
    end else if (msg_strobe) begin
      process_word <= word_next;
    end
  end
endmodule
`default_nettype wire

// *** dv/scaling_checker.sv ***
// checker: answer timing, refusals and message timing of the scaling block
`timescale 1ns/1ps
`default_nettype none
module scaling_checker
  import encoder_scaling_pkg::*;
#(
  parameter int ANGLE_BITS = 12,
  parameter int TURN_BITS = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ANGLE_BITS-1:0] sensor_angle,
  input wire logic [TURN_BITS-1:0] sensor_turns,
  input wire logic msg_strobe,
  input wire logic par_req,
  input wire logic par_write,
  input wire logic [15:0] par_index,
  input wire logic [7:0] par_subindex,
  input wire logic [31:0] par_wdata,
  input wire logic par_ack,
  input wire logic par_abort,
  input wire logic [31:0] par_abort_code,
  input wire logic [31:0] par_rdata,
  input wire logic [31:0] process_word,
  input wire logic process_valid
);
  localparam logic [31:0] STEPS_MAX = 32'h1 << ANGLE_BITS;
  localparam logic [31:0] TOTAL_MAX = 32'h1 << (ANGLE_BITS + TURN_BITS);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // write requests and any access to the count entry
  sequence s_wr(idx); par_req && par_write && par_index == idx; endsequence
  sequence s_cnt; par_index == IDX_USER_STORE && par_subindex == 8'h00; endsequence
  property p_ack;
    par_req |=> par_ack && (par_abort == (par_abort_code != ABORT_NONE));
  endproperty
  a_ack: assert property (p_ack) else $error("answer missing or inconsistent");
  property p_steps;
    s_wr(IDX_STEPS_PER_TURN) ##0 par_wdata > STEPS_MAX
      |=> par_abort && par_abort_code == ABORT_VALUE_RANGE;
  endproperty
  a_steps: assert property (p_steps) else $error("steps overflow taken");
  property p_total;
    s_wr(IDX_TOTAL_MEASURING_UNITS) ##0 par_wdata > TOTAL_MAX
      |=> par_abort && par_abort_code == ABORT_VALUE_RANGE;
  endproperty
  a_total: assert property (p_total) else $error("total overflow taken");
  property p_cnt_ro;
    par_req && par_write ##0 s_cnt |=> par_abort_code == ABORT_READ_ONLY;
  endproperty
  a_cnt_ro: assert property (p_cnt_ro) else $error("count written");
  property p_cnt;
    par_req && !par_write ##0 s_cnt |=> par_rdata == 32'h4 && !par_abort;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count wrong");
  property p_msg; msg_strobe |=> process_valid; endproperty
  a_msg: assert property (p_msg) else $error("message not answered");
  property p_hold; !msg_strobe |=> !process_valid && $stable(process_word); endproperty
  a_hold: assert property (p_hold) else $error("word moved without message");
  property p_range; process_valid |-> process_word[29:0] < TOTAL_MAX; endproperty
  a_range: assert property (p_range) else $error("value beyond range");
endmodule
bind encoder_position_scaling_limits scaling_checker #(.ANGLE_BITS(ANGLE_BITS),
  .TURN_BITS(TURN_BITS)) scaling_checker_inst (.mclk, .rst_n, .sensor_angle, .sensor_turns,
  .msg_strobe, .par_req, .par_write, .par_index, .par_subindex, .par_wdata, .par_ack,
  .par_abort, .par_abort_code, .par_rdata, .process_word, .process_valid);
`default_nettype wire

// *** dv/bus_master_model.sv ***
// fieldbus master model: one parameter access per call
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input wire logic mclk,
  output logic par_req,
  output logic par_write,
  output logic [15:0] par_index,
  output logic [7:0] par_subindex,
  output logic [31:0] par_wdata,
  input wire logic par_ack,
  input wire logic [31:0] par_abort_code,
  input wire logic [31:0] par_rdata
);
  // idle at time zero
  initial begin
    par_req = 1'h0;
    par_write = 1'h0;
    par_index = '0;
    par_subindex = '0;
    par_wdata = '0;
  end
  // one-cycle request; answer read while the ack pulse stands, then released
  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] d, output logic a, output logic [31:0] c, output logic [31:0] r);
    @(negedge mclk);
    par_req = 1'h1;
    par_write = w;
    par_index = idx;
    par_subindex = sub;
    par_wdata = d;
    @(negedge mclk);
    a = par_ack;
    c = par_abort_code;
    r = par_rdata;
    par_req = 1'h0;
    par_wdata = ~d; // released data no longer shows the word
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// testbench: parameter access, scaling, preset and limit flags
`timescale 1ns/1ps
`default_nettype none
module tb;
  import encoder_scaling_pkg::*;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] sensor_angle = 4'h6;
  logic [3:0] sensor_turns = 4'ha;
  logic msg_strobe = 1'h0;
  logic par_req, par_write, par_ack, par_abort, process_valid;
  logic [15:0] par_index;
  logic [7:0] par_subindex;
  logic [31:0] par_wdata, par_abort_code, par_rdata, process_word;
  logic [31:0] rv [6] = '{32'h0, 32'h10, 32'h100, 32'h0, 32'h0, 32'h0};
  int errors = 0;
  int n_tests = 0;
  always #2.5 mclk = ~mclk;
  encoder_position_scaling_limits #(.ANGLE_BITS(4), .TURN_BITS(4))
    encoder_position_scaling_limits_inst (.mclk, .rst_n, .sensor_angle, .sensor_turns,
    .msg_strobe, .par_req, .par_write, .par_index, .par_subindex, .par_wdata, .par_ack,
    .par_abort, .par_abort_code, .par_rdata, .process_word, .process_valid);
  bus_master_model bus_master_model_inst (.mclk, .par_req, .par_write, .par_index,
    .par_subindex, .par_wdata, .par_ack, .par_abort_code, .par_rdata);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one access, compare answer, code and read data
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d, input logic [31:0] c, input logic [31:0] r);
    logic a;
    logic [31:0] cs, rs;
    bus_master_model_inst.access(w, i, s, d, a, cs, rs);
    check({31'h0, a}, 32'h1);
    check(cs, c);
    check(rs, r);
  endtask
  // one message, compare the process word
  task automatic msg(input logic [31:0] w);
    @(negedge mclk);
    msg_strobe = 1'h1;
    @(negedge mclk);
    check({31'h0, process_valid}, 32'h1);
    check(process_word, w);
    msg_strobe = 1'h0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    errors++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (20) @(negedge mclk);
    rst_n = 1'h1;
    foreach (rv[i]) acc(1'h0, IDX_OPERATING_OPTIONS + 16'(i), '0, '0, '0, rv[i]);
    acc(1'h0, IDX_USER_STORE, '0, '0, '0, 32'h4);
    acc(1'h1, IDX_USER_STORE, '0, 32'h9, ABORT_READ_ONLY, '0);
    for (int i = 1; i <= 4; i++) begin
      acc(1'h1, IDX_USER_STORE, 8'(i), 32'ha5a5_0000 + i, '0, '0);
      acc(1'h0, IDX_USER_STORE, 8'(i), '0, '0, 32'ha5a5_0000 + i);
    end
    acc(1'h0, 16'h2106, '0, '0, ABORT_NO_OBJECT, '0);
    acc(1'h0, IDX_USER_STORE, 8'h05, '0, ABORT_NO_SUBINDEX, '0);
    acc(1'h1, IDX_OPERATING_OPTIONS, '0, 32'h100, ABORT_VALUE_RANGE, '0);
    msg(32'ha6);
    acc(1'h1, IDX_STEPS_PER_TURN, '0, 32'h11, ABORT_VALUE_RANGE, '0);
    acc(1'h1, IDX_STEPS_PER_TURN, '0, 32'h8, '0, '0);
    msg(32'h53);
    acc(1'h1, IDX_TOTAL_MEASURING_UNITS, '0, 32'h101, ABORT_VALUE_RANGE, '0);
    acc(1'h1, IDX_TOTAL_MEASURING_UNITS, '0, 32'h40, '0, '0);
    msg(32'h13);
    acc(1'h1, IDX_OPERATING_OPTIONS, '0, 32'h1, '0, '0);
    msg(32'h2c);
    acc(1'h1, IDX_PRESET_POSITION, '0, 32'h41, ABORT_VALUE_RANGE, '0);
    acc(1'h1, IDX_PRESET_POSITION, '0, 32'h5, '0, '0);
    msg(32'h5);
    sensor_angle = 4'h8; // shaft moves on, complemented count falls
    msg(32'h4);
    sensor_angle = 4'h6;
    acc(1'h1, IDX_LOWER_LIMIT_VALUE, '0, 32'h41, ABORT_VALUE_RANGE, '0);
    acc(1'h1, IDX_UPPER_LIMIT_VALUE, '0, 32'h41, ABORT_VALUE_RANGE, '0);
    acc(1'h1, IDX_LOWER_LIMIT_VALUE, '0, 32'ha, '0, '0);
    acc(1'h1, IDX_OPERATING_OPTIONS, '0, 32'h3, '0, '0);
    msg(32'h4000_0005);
    acc(1'h1, IDX_UPPER_LIMIT_VALUE, '0, 32'h5, '0, '0);
    acc(1'h1, IDX_OPERATING_OPTIONS, '0, 32'h7, '0, '0);
    msg(32'hc000_0005);
    acc(1'h1, IDX_UPPER_LIMIT_VALUE, '0, 32'h6, '0, '0);
    msg(32'h4000_0005);
    acc(1'h1, IDX_OPERATING_OPTIONS, '0, 32'h1, '0, '0);
    msg(32'h5);
    tally_and_finish;
  end
endmodule
`default_nettype wire
